// ==== pkg/pfs_pkg.sv ====
// Constants for the fault supervisor: register map, field positions, mask times.
// Assumes one 20 MHz core clock; all mask times are counted in that clock.
// Behaviour
// [R1] With the reload bit set, stored settings are copied into the live table and writes are ignored.
// [R2] With the reload bit clear, host writes to writable configuration bits are taken normally.
// [R3] The supply-overvoltage flag sets on that protection and clears on enable low or hiccup restart.
// [R4] The overcurrent flag sets on any overcurrent protection and clears only on enable low.
// [R5] Each error flag reads one after its event since the last clear, else zero, and is read-only.
// [R6] A supply lockout held for 32 us disables all channels, restarting once supply is good and enabled.
// [R7] A supply overvoltage held for its 5 ms mask disables all channels, restarting once it clears.
// [R8] Switching-channel overcurrent held through the 10 ms mask disables all channels.
// [R9] Overcurrent, undervoltage and load-switch faults latch all channels off until analog supply low or enable low.
// [R10] First-channel output overvoltage, with no mask, disables only that channel until it clears.
// [R11] Over-temperature latches all channels off until enable is high and the die has cooled.
// [R12] Linear regulator undervoltage acts with no mask, sooner than the overcurrent mask.
// [R13] A fault counts only if held for its whole mask time; a shorter pulse restarts the count.
// [R14] The normal-read inhibit bit blocks the power-on copy of stored settings; clear allows it.
package pfs_pkg;
   // ==========================================================================
   // Register map
   localparam logic [7:0] ADDR_CFG = 8'h0D;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] CFG_RESET = 8'h0A;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] CFG_WR_MASK = 8'h07;
   localparam int CFG_OVP_TYPE_BIT = 2;
   localparam int BIT_INHIBIT = 7;
   localparam int BIT_RELOAD = 6;
   localparam int BIT_LOCKOUT = 4;
   localparam int BIT_OVP = 3;
   localparam int BIT_OTP = 2;
   localparam int BIT_UVP = 1;
   localparam int BIT_OCP = 0;
   // ==========================================================================
   // Timing
   localparam int CLK_MHZ = 20;
   localparam int LOCKOUT_MASK_NS = 32000;
   localparam int OVP_1MS_US = 1000;
   localparam int OVP_5MS_US = 5000;
   localparam int OCP_MASK_US = 10000;
   localparam int CNT_W = 18;
   localparam int LOCKOUT_MASK_CYC = (LOCKOUT_MASK_NS * CLK_MHZ + 999) / 1000;
   localparam int OVP_1MS_CYC = OVP_1MS_US * CLK_MHZ;
   localparam int OVP_5MS_CYC = OVP_5MS_US * CLK_MHZ;
   localparam int OCP_MASK_CYC = OCP_MASK_US * CLK_MHZ;
   localparam logic [1:0] OVP_SEL_0MS = 2'h0;
   localparam logic [1:0] OVP_SEL_1MS = 2'h1;
   localparam logic [1:0] OVP_SEL_5MS = 2'h2;
   // ==========================================================================
   // Supervisor states
   typedef enum logic [2:0] {
      PFS_OFF = 3'b000,
      PFS_ON = 3'b001,
      PFS_HICCUP = 3'b010,
      PFS_LATCH = 3'b011,
      PFS_THERM = 3'b100
   } pfs_state_t;
endpackage : pfs_pkg

// ==== rtl/pfs_fault_supervisor.sv ====
// Fault supervisor: qualifies comparator faults, shuts channels down, keeps sticky flags.
// Assumes comparator and pin inputs are asynchronous; the register port and stored
// settings come from logic on the core clock (the two-wire front end and the store).
module pfs_fault_supervisor #(
   parameter int OVP_1MS = pfs_pkg::OVP_1MS_CYC,
   parameter int OVP_5MS = pfs_pkg::OVP_5MS_CYC,
   parameter int OVP_10MS = pfs_pkg::OCP_MASK_CYC,
   parameter int OCP_MASK = pfs_pkg::OCP_MASK_CYC
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic CHIP_ENABLE_PIN_I,
   input wire logic ANALOG_SUPPLY_LOW_I,
   input wire logic VIN_LOW_I,
   input wire logic VIN_GOOD_I,
   input wire logic INPUT_OVERVOLTAGE_EVENT_I,
   input wire logic VIN_OV_CLEAR_I,
   input wire logic [3:0] OCP_I,
   input wire logic [3:0] UVP_I,
   input wire logic LOAD_SWITCH_FAULT_I,
   input wire logic VOUT1_OV_I,
   input wire logic TEMP_HOT_I,
   input wire logic TEMP_COOL_I,
   input wire logic [7:0] NV_CFG_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   output logic [7:0] REG_RDATA_O,
   output logic [4:0] CH_EN_O
);
   // ==========================================================================
   // Input synchronisers
   localparam int SYNC_W = 18;
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   logic en, ana_low, vin_low, vin_good, vin_ov, vin_ov_clr, lsw_f, v1_ov, hot, cool;
   logic [3:0] ocp;
   logic [3:0] uvp;

   // Two stages on every async input; only sync2 is read by logic
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= {CHIP_ENABLE_PIN_I, ANALOG_SUPPLY_LOW_I, VIN_LOW_I, VIN_GOOD_I,
                   INPUT_OVERVOLTAGE_EVENT_I, VIN_OV_CLEAR_I, OCP_I, UVP_I,
                   LOAD_SWITCH_FAULT_I, VOUT1_OV_I, TEMP_HOT_I, TEMP_COOL_I};
         sync2 <= sync1;
      end
   end
   assign {en, ana_low, vin_low, vin_good, vin_ov, vin_ov_clr, ocp, uvp,
           lsw_f, v1_ov, hot, cool} = sync2;

   // ==========================================================================
   // Mask counters
   logic [pfs_pkg::CNT_W-1:0] lo_cnt;
   logic [pfs_pkg::CNT_W-1:0] ov_cnt;
   logic [pfs_pkg::CNT_W-1:0] oc_cnt;
   logic [pfs_pkg::CNT_W-1:0] ov_mask;
   logic [7:0] cfg;
   logic [7:0] status;
   logic any_ocp, lo_fire, ov_fire, oc_fire, latch_fire, stop_all;

   assign any_ocp = |ocp;

   // Selected overvoltage deglitch time from the live configuration
   always_comb
   begin
      case (cfg[1:0])
         pfs_pkg::OVP_SEL_0MS: ov_mask = '0;
         pfs_pkg::OVP_SEL_1MS: ov_mask = pfs_pkg::CNT_W'(OVP_1MS);
         pfs_pkg::OVP_SEL_5MS: ov_mask = pfs_pkg::CNT_W'(OVP_5MS);
         default: ov_mask = pfs_pkg::CNT_W'(OVP_10MS);
      endcase
   end

   // Counters run while the fault holds and drop to zero on any gap
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         lo_cnt <= '0;
         ov_cnt <= '0;
         oc_cnt <= '0;
      end
      else
      begin
         lo_cnt <= !vin_low ? '0 : (lo_fire ? lo_cnt : lo_cnt + 1'b1); // R13
         ov_cnt <= !vin_ov ? '0 : (ov_fire ? ov_cnt : ov_cnt + 1'b1); // R13
         oc_cnt <= !any_ocp ? '0 : (oc_fire ? oc_cnt : oc_cnt + 1'b1); // R13
      end
   end

   assign lo_fire = vin_low && (lo_cnt >= pfs_pkg::CNT_W'(pfs_pkg::LOCKOUT_MASK_CYC - 1)); // R6
   assign ov_fire = vin_ov && (ov_cnt >= ov_mask); // R7
   assign oc_fire = any_ocp && (oc_cnt >= pfs_pkg::CNT_W'(OCP_MASK - 1)); // R8
   // Undervoltage, including the linear regulator's, needs no mask
   assign latch_fire = oc_fire || (|uvp) || lsw_f; // R9 R12
   assign stop_all = lo_fire || ov_fire || latch_fire || hot;

   // ==========================================================================
   // Supervisor state machine
   pfs_pkg::pfs_state_t state;
   pfs_pkg::pfs_state_t next_state;
   logic hic_ov;
   logic restart;

   always_comb
   begin
      next_state = state;
      case (state)
         pfs_pkg::PFS_OFF:
            if (en && !ana_low)
               next_state = pfs_pkg::PFS_ON;
         pfs_pkg::PFS_ON:
            if (hot)
               next_state = pfs_pkg::PFS_THERM; // R11
            else if (latch_fire)
               next_state = pfs_pkg::PFS_LATCH; // R9
            else if (ov_fire && cfg[pfs_pkg::CFG_OVP_TYPE_BIT])
               next_state = pfs_pkg::PFS_LATCH;
            else if (lo_fire || ov_fire)
               next_state = pfs_pkg::PFS_HICCUP; // R6 R7
         pfs_pkg::PFS_HICCUP:
            if (en && (hic_ov ? vin_ov_clr : vin_good))
               next_state = pfs_pkg::PFS_ON;
         pfs_pkg::PFS_THERM:
            if (en && cool)
               next_state = pfs_pkg::PFS_ON; // R11
         pfs_pkg::PFS_LATCH:
            next_state = pfs_pkg::PFS_LATCH;
         default:
            next_state = pfs_pkg::PFS_OFF;
      endcase
      // Enable low or analog supply collapse releases every latch
      if (!en || ana_low)
         next_state = pfs_pkg::PFS_OFF; // R9
   end

   assign restart = (state == pfs_pkg::PFS_HICCUP) && (next_state == pfs_pkg::PFS_ON);

   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state <= pfs_pkg::PFS_OFF;
         hic_ov <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == pfs_pkg::PFS_ON && next_state == pfs_pkg::PFS_HICCUP)
            hic_ov <= ov_fire;
      end
   end

   // Channel enables: ch1 alone drops on its own output overvoltage and retries when clear
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         CH_EN_O <= '0;
      else if (state == pfs_pkg::PFS_ON && !stop_all)
         CH_EN_O <= {4'hF, !v1_ov}; // R10
      else
         CH_EN_O <= '0; // R6 R7 R8 R9 R11
   end

   // ==========================================================================
   // Registers
   logic power_on;
   logic wr_cfg, wr_status;
   logic [7:0] next_flags;
   logic [7:0] clr_flags;

   assign power_on = (state == pfs_pkg::PFS_OFF) && (next_state == pfs_pkg::PFS_ON);
   assign wr_cfg = REG_WR_I && (REG_ADDR_I == pfs_pkg::ADDR_CFG);
   assign wr_status = REG_WR_I && (REG_ADDR_I == pfs_pkg::ADDR_STATUS);

   // Live configuration; reload overrides and blocks host writes
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cfg <= pfs_pkg::CFG_RESET;
      else if (status[pfs_pkg::BIT_RELOAD])
         cfg <= NV_CFG_I; // R1
      else if (power_on && !status[pfs_pkg::BIT_INHIBIT])
         cfg <= NV_CFG_I; // R14
      else if (wr_cfg)
         cfg <= (cfg & ~pfs_pkg::CFG_WR_MASK) | (REG_WDATA_I & pfs_pkg::CFG_WR_MASK); // R2
   end

   // Flag sets and clears; a set in the clearing cycle wins
   always_comb
   begin
      next_flags = '0;
      clr_flags = '0;
      next_flags[pfs_pkg::BIT_LOCKOUT] = lo_fire;
      next_flags[pfs_pkg::BIT_OVP] = ov_fire; // R3
      next_flags[pfs_pkg::BIT_OTP] = hot;
      next_flags[pfs_pkg::BIT_UVP] = |uvp;
      next_flags[pfs_pkg::BIT_OCP] = any_ocp && oc_fire; // R4
      clr_flags[pfs_pkg::BIT_LOCKOUT] = !en || restart;
      clr_flags[pfs_pkg::BIT_OVP] = !en || restart; // R3
      clr_flags[pfs_pkg::BIT_OTP] = !en || restart;
      clr_flags[pfs_pkg::BIT_UVP] = !en;
      clr_flags[pfs_pkg::BIT_OCP] = !en; // R4
   end

   // Control bits: only the reload bit stays writable while reload is set,
   // otherwise software could never leave reload mode
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         status <= pfs_pkg::STATUS_RESET;
      else
      begin
         status[4:0] <= next_flags[4:0] | (status[4:0] & ~clr_flags[4:0]); // R5
         if (wr_status)
         begin
            status[pfs_pkg::BIT_RELOAD] <= REG_WDATA_I[pfs_pkg::BIT_RELOAD];
            if (!status[pfs_pkg::BIT_RELOAD])
               status[pfs_pkg::BIT_INHIBIT] <= REG_WDATA_I[pfs_pkg::BIT_INHIBIT]; // R1 R2
         end
      end
   end

   // Read data follows the address one cycle later; unmapped reads give zero
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         REG_RDATA_O <= '0;
      else if (REG_ADDR_I == pfs_pkg::ADDR_STATUS)
         REG_RDATA_O <= status; // R5
      else if (REG_ADDR_I == pfs_pkg::ADDR_CFG)
         REG_RDATA_O <= cfg;
      else
         REG_RDATA_O <= '0;
   end

   // ==========================================================================
   // Assertions
   property p_reload_copy;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      status[pfs_pkg::BIT_RELOAD] |=> cfg == $past(NV_CFG_I);
   endproperty
   a_reload_copy: assert property (p_reload_copy) else $error("reload did not copy"); // R1

   property p_cfg_write;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      wr_cfg && !status[pfs_pkg::BIT_RELOAD] && !power_on
      |=> cfg[2:0] == $past(REG_WDATA_I[2:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // R2

   property p_ovp_flag;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      ov_fire |=> status[pfs_pkg::BIT_OVP];
   endproperty
   a_ovp_flag: assert property (p_ovp_flag) else $error("overvoltage flag not set"); // R3

   property p_ocp_hold;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      status[pfs_pkg::BIT_OCP] && en |=> status[pfs_pkg::BIT_OCP];
   endproperty
   a_ocp_hold: assert property (p_ocp_hold) else $error("overcurrent flag cleared"); // R4

   property p_read_back;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      REG_ADDR_I == pfs_pkg::ADDR_STATUS |=> REG_RDATA_O == $past(status) && !REG_RDATA_O[5];
   endproperty
   a_read_back: assert property (p_read_back) else $error("status read mismatch"); // R5

   property p_lockout_off;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      lo_fire |=> CH_EN_O == 5'h00 ##1 CH_EN_O == 5'h00;
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("lockout left channels on"); // R6

   property p_latch_hold;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      state == pfs_pkg::PFS_LATCH && en && !ana_low |=> state == pfs_pkg::PFS_LATCH;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch released early"); // R9

   property p_ch1_ov;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      state == pfs_pkg::PFS_ON && !stop_all && v1_ov |=> CH_EN_O == 5'h1E;
   endproperty
   a_ch1_ov: assert property (p_ch1_ov) else $error("ch1 overvoltage mishandled"); // R10

   property p_thermal;
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      hot |=> CH_EN_O == 5'h00;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal left channels on"); // R11
endmodule : pfs_fault_supervisor

// ==== tb/pfs_fault_supervisor_tb.sv ====
// Self-checking bench for the fault supervisor: register port and fault inputs.
// Assumes short mask parameters (10, 20, 30, 40 cycles) and a 640-cycle lockout mask.
module pfs_fault_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Stimulus signals
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic ana_low = 1'b0;
   logic vin_low = 1'b0;
   logic vin_good = 1'b1;
   logic ov = 1'b0;
   logic ov_clr = 1'b1;
   logic [3:0] ocp = 4'h0;
   logic [3:0] uvp = 4'h0;
   logic load_switch = 1'b0;
   logic v1ov = 1'b0;
   logic hot = 1'b0;
   logic cool = 1'b1;
   logic [7:0] nv = 8'h09; // Hiccup type, 1 ms deglitch
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic [7:0] rdata;
   logic [4:0] ch_en;
   int n_fail = 0;
   int tests_run = 0;
   // ==========================================================================
   // Clock, design and host
   always #25 clk = ~clk;
   pfs_fault_supervisor #(.OVP_1MS(10), .OVP_5MS(20), .OVP_10MS(30), .OCP_MASK(40))
   pfs_fault_supervisor_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CHIP_ENABLE_PIN_I(en),
      .ANALOG_SUPPLY_LOW_I(ana_low), .VIN_LOW_I(vin_low), .VIN_GOOD_I(vin_good),
      .INPUT_OVERVOLTAGE_EVENT_I(ov), .VIN_OV_CLEAR_I(ov_clr), .OCP_I(ocp), .UVP_I(uvp),
      .LOAD_SWITCH_FAULT_I(load_switch), .VOUT1_OV_I(v1ov), .TEMP_HOT_I(hot), .TEMP_COOL_I(cool),
      .NV_CFG_I(nv), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
      .REG_RDATA_O(rdata), .CH_EN_O(ch_en));
   pfs_host_model pfs_host_model_inst (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr));
   // ==========================================================================
   // Comparison helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      pfs_host_model_inst.rd(a, d);
      chk(d, exp);
   endtask : rchk
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // Enable low then high; two sync edges plus a state step fit in the waits
   task automatic en_cycle();
      en = 1'b0;
      wt(6);
      en = 1'b1;
      wt(6);
   endtask : en_cycle
   // Overvoltage under one hiccup deglitch code: a pulse two cycles short of the
   // mask must be ignored, a hold past it shuts down, and a clear supply restarts
   task automatic ovp_try(input logic [7:0] code, input int mask);
      pfs_host_model_inst.wr(8'h0D, code);
      ov = 1'b1;
      wt(mask - 2);
      ov = 1'b0;
      wt(4);
      chk({3'h0, ch_en}, 8'h1F);
      ov = 1'b1;
      ov_clr = 1'b0;
      wt(mask + 4);
      chk({3'h0, ch_en}, 8'h00);
      ov = 1'b0;
      ov_clr = 1'b1;
      wt(8);
      chk({3'h0, ch_en}, 8'h1F);
   endtask : ovp_try
   task automatic endt(input string name);
      $display("test %s done, checks %0d, failures %0d", name, tests_run, n_fail);
   endtask : endt
   task automatic final_report();
      $display("checks %0d, failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // ==========================================================================
   // Watchdog: the sequence needs about 1200 cycles
   initial
   begin
      #(50 * 20000);
      n_fail++;
      final_report();
   end
   // ==========================================================================
   // Test sequence
   initial
   begin
      wt(10);
      rst_n = 1'b1;
      rchk(8'h0D, 8'h0A);
      rchk(8'h10, 8'h00);
      rchk(8'h20, 8'h00);
      chk({3'h0, ch_en}, 8'h00);
      endt("reset");
      en = 1'b1;
      wt(6);
      chk({3'h0, ch_en}, 8'h1F);
      rchk(8'h0D, nv);
      pfs_host_model_inst.wr(8'h0D, 8'h03);
      rchk(8'h0D, 8'h0B);
      pfs_host_model_inst.wr(8'h10, 8'h5F);
      rchk(8'h10, 8'h40);
      pfs_host_model_inst.wr(8'h0D, 8'h05);
      rchk(8'h0D, nv);
      pfs_host_model_inst.wr(8'h10, 8'h00);
      rchk(8'h10, 8'h00);
      endt("registers");
      ov = 1'b1;
      wt(8);
      ov = 1'b0;
      wt(4);
      chk({3'h0, ch_en}, 8'h1F);
      ov = 1'b1;
      ov_clr = 1'b0;
      wt(20);
      chk({3'h0, ch_en}, 8'h00);
      rchk(8'h10, 8'h08);
      ov = 1'b0;
      ov_clr = 1'b1;
      wt(8);
      chk({3'h0, ch_en}, 8'h1F);
      rchk(8'h10, 8'h00);
      endt("overvoltage");
      // Remaining deglitch codes, then latch-off type with no deglitch
      ovp_try(8'h02, 20);
      ovp_try(8'h03, 30);
      pfs_host_model_inst.wr(8'h0D, 8'h04);
      ov = 1'b1;
      ov_clr = 1'b0;
      wt(4);
      chk({3'h0, ch_en}, 8'h00);
      ov = 1'b0;
      ov_clr = 1'b1;
      wt(8);
      chk({3'h0, ch_en}, 8'h00);
      rchk(8'h10, 8'h08);
      en_cycle();
      rchk(8'h10, 8'h00);
      chk({3'h0, ch_en}, 8'h1F);
      rchk(8'h0D, nv);
      endt("overvoltage modes");
      vin_low = 1'b1;
      vin_good = 1'b0;
      wt(600);
      chk({3'h0, ch_en}, 8'h1F);
      wt(100);
      chk({3'h0, ch_en}, 8'h00);
      rchk(8'h10, 8'h10);
      vin_low = 1'b0;
      vin_good = 1'b1;
      wt(8);
      chk({3'h0, ch_en}, 8'h1F);
      endt("lockout");
      v1ov = 1'b1;
      wt(5);
      chk({3'h0, ch_en}, 8'h1E);
      v1ov = 1'b0;
      wt(5);
      chk({3'h0, ch_en}, 8'h1F);
      endt("ch1 overvoltage");
      ocp = 4'h4;
      wt(20);
      ocp = 4'h0;
      wt(4);
      chk({3'h0, ch_en}, 8'h1F);
      ocp = 4'h8;
      wt(50);
      chk({3'h0, ch_en}, 8'h00);
      ocp = 4'h0;
      wt(10);
      chk({3'h0, ch_en}, 8'h00);
      rchk(8'h10, 8'h01);
      ana_low = 1'b1;
      wt(6);
      ana_low = 1'b0;
      wt(6);
      chk({3'h0, ch_en}, 8'h1F);
      rchk(8'h10, 8'h01);
      en_cycle();
      rchk(8'h10, 8'h00);
      endt("overcurrent");
      uvp = 4'h2;
      wt(5);
      chk({3'h0, ch_en}, 8'h00);
      uvp = 4'h0;
      rchk(8'h10, 8'h02);
      en_cycle();
      load_switch = 1'b1;
      wt(5);
      chk({3'h0, ch_en}, 8'h00);
      load_switch = 1'b0;
      en_cycle();
      endt("undervoltage");
      hot = 1'b1;
      cool = 1'b0;
      wt(5);
      chk({3'h0, ch_en}, 8'h00);
      hot = 1'b0;
      wt(5);
      chk({3'h0, ch_en}, 8'h00);
      rchk(8'h10, 8'h04);
      cool = 1'b1;
      wt(6);
      chk({3'h0, ch_en}, 8'h1F);
      endt("thermal");
      pfs_host_model_inst.wr(8'h10, 8'h80);
      pfs_host_model_inst.wr(8'h0D, 8'h03);
      en_cycle();
      rchk(8'h0D, 8'h0B);
      pfs_host_model_inst.wr(8'h10, 8'h00);
      en_cycle();
      rchk(8'h0D, nv);
      endt("inhibit");
      final_report();
   end
endmodule : pfs_fault_supervisor_tb

// ==== tb/pfs_host_model.sv ====
// Host side of the register port: single-byte writes and reads on the core clock.
// Assumes the block shows read data one edge after the address is presented.
module pfs_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Idle levels at time zero
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
   end
   // ==========================================================================
   // Bus cycles, changed on the falling edge so the rising edge sees settled values
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1; // One-cycle strobe
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~d; // Released data must not look like the last byte
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      @(negedge clk_i);
      d = rdata_i; // Registered answer, one edge after the address
   endtask : rd
endmodule : pfs_host_model
